// ---- cfsync_pkg.sv ----
// Constants and types shared by the CPU end and the fieldbus master end of the cycle synchronizer.
// Assumes one system clock for both ends.
package cfsync_pkg;
   // ------------------------------------------------------------
   // Modes of the serial interface function
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CFS_MODE_OFF    = 3'h0,
      CFS_MODE_PTP    = 3'h1,
      CFS_MODE_ASYNC  = 3'h2,
      CFS_MODE_IN     = 3'h3,
      CFS_MODE_OUT    = 3'h4,
      CFS_MODE_MUTUAL = 3'h5
   } cfs_mode_t;
   localparam cfs_mode_t CFS_MODE_RESET = CFS_MODE_ASYNC;
   localparam int CFS_NUM_MASTERS = 2;
   localparam int CFS_DATA_W = 16;
   // ------------------------------------------------------------
   // Avalon-MM register offsets (word index = byte address / 4)
   // ------------------------------------------------------------
   localparam logic [3:0] CFS_REG_CTRL = 4'h0;
   localparam logic [3:0] CFS_REG_STATUS = 4'h1;
   localparam logic [3:0] CFS_REG_OUTDATA = 4'h2;
   localparam logic [3:0] CFS_REG_INDATA = 4'h3;
   localparam logic [3:0] CFS_REG_CYCLES = 4'h4;
   localparam logic [3:0] CFS_REG_MCFG = 4'h5;
   localparam logic [3:0] CFS_REG_MSTAT = 4'h6;
   // Field positions.
   localparam int CFS_CTRL_MODE_LSB = 0;
   localparam int CFS_CTRL_RUN_BIT = 4;
   localparam int CFS_CTRL_DONE_BIT = 5;
   localparam int CFS_MCFG_ENA_LSB = 0;
   localparam int CFS_MCFG_LEN_LSB = 16;
   // Reset values.
   localparam logic [15:0] CFS_MCYC_LEN_RESET = 16'h0010;
   localparam logic [15:0] CFS_CPU_DATA_RESET = 16'h0000;
endpackage : cfsync_pkg

// ---- cfsync_if.sv ----
// Interface joining the CPU end to the fieldbus master units.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ns
`default_nettype none
interface cfsync_if #(parameter int NM = cfsync_pkg::CFS_NUM_MASTERS, parameter int DW = cfsync_pkg::CFS_DATA_W);
   // Mode and run state from the CPU.
   logic [2:0] mode;
   logic run;
   // Output data with its sync pulse, CPU to masters.
   logic out_sync;
   logic [DW-1:0] out_data;
   // Per-master input sync pulses with data, masters to CPU.
   logic [NM-1:0] in_sync;
   logic [NM*DW-1:0] in_data;
   // Configured masters.
   logic [NM-1:0] master_ena;
   modport cpu (output mode, output run, output out_sync, output out_data, output master_ena,
                input in_sync, input in_data);
   modport master (input mode, input run, input out_sync, input out_data, input master_ena,
                   output in_sync, output in_data);
endinterface : cfsync_if
`default_nettype wire

// ---- cfsync_cpu.sv ----
// CPU end of the cycle synchronizer: program-scan sequencer with an Avalon-MM register slave.
// Assumes the master end shares mclk and answers on the cfsync_if master modport.
// What this block does
// - Async mode: CPU and masters never wait
// - Cycle is read inputs, program, write outputs
// - Each master keeps its own cycle timing
// - Mutual mode: both sides wait each other
// - Mutual cycle equals CPU plus longest master
// - Mutual mode: one consistent data set per cycle
// - Raise bus watchdog for long waits
// - Output sync: master cycle follows CPU cycle
// - Output sync: masters synced after CPU start-up
// - Output sync: master idles until next pulse
// - Output sync: CPU sends outputs with pulse
// - Input sync: CPU paced by slowest master
// - Input sync: sync with all masters entering RUN
// - Input sync: CPU waits for next input pulse
// - Input sync: raise scan cycle monitoring time
// - Mode setting six choices, async default
// - Point-to-point disables the master function
`timescale 1ns/1ns
`default_nettype none
module cfsync_cpu
   import cfsync_pkg::*;
#(
   parameter int NM = cfsync_pkg::CFS_NUM_MASTERS,
   parameter int DW = cfsync_pkg::CFS_DATA_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Link to the masters
   cfsync_if.cpu link
);
   import cfsync_pkg::*;
   // ------------------------------------------------------------
   // Scan sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {CFS_IDLE, CFS_READ_IN, CFS_EXEC, CFS_WAIT_IN} cfs_state_t;
   cfs_state_t state_q, state_d;
   logic [2:0] mode_q;
   logic run_q;
   logic [NM-1:0] ena_q;
   logic [15:0] mlen_q;
   logic [DW-1:0] out_reg_q, out_data_q, in_img_q;
   logic [NM*DW-1:0] in_cap_q;
   logic [NM-1:0] got_q;
   logic out_sync_q;
   logic [15:0] cycles_q;
   logic ack_q;
   logic [31:0] rdata_q;
   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire logic acc = (avs_read | avs_write) & ~ack_q;
   wire logic wr = avs_write & ~ack_q;
   wire logic wr_ctrl = wr & (avs_address == CFS_REG_CTRL);
   wire logic wr_out = wr & (avs_address == CFS_REG_OUTDATA);
   wire logic wr_mcfg = wr & (avs_address == CFS_REG_MCFG);
   wire logic done = wr_ctrl & avs_writedata[CFS_CTRL_DONE_BIT];
   wire logic [2:0] mode_wr = avs_writedata[CFS_CTRL_MODE_LSB +: 3];
   // Reserved mode codes are dropped so the link never carries an undefined mode.
   wire logic mode_ok = (mode_wr <= 3'(CFS_MODE_MUTUAL));
   wire logic dp_on = (mode_q != CFS_MODE_OFF) && (mode_q != CFS_MODE_PTP);
   wire logic wait_in = dp_on && ((mode_q == CFS_MODE_IN) || (mode_q == CFS_MODE_MUTUAL));
   wire logic [NM-1:0] need = ena_q;
   wire logic [NM-1:0] got_now = got_q | (link.in_sync & ena_q);
   wire logic all_in = ((got_now & need) == need);
   // Output data go out with the pulse at the end of every program pass, except in the off and point-to-point modes.
   wire logic send_out = (state_q == CFS_EXEC) && done && dp_on && run_q;
   assign link.mode = mode_q;
   assign link.run = run_q;
   assign link.out_sync = out_sync_q;
   assign link.out_data = out_data_q;
   assign link.master_ena = ena_q;
   assign avs_waitrequest = acc;
   assign avs_readdata = rdata_q;
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         CFS_IDLE: begin
            if (run_q) begin
               state_d = wait_in ? CFS_WAIT_IN : CFS_READ_IN;
            end
         end
         CFS_READ_IN: state_d = CFS_EXEC;
         CFS_EXEC: begin
            if (!run_q) begin
               state_d = CFS_IDLE;
            end else if (done) begin
               state_d = wait_in ? CFS_WAIT_IN : CFS_READ_IN;
            end
         end
         // The wait has no time limit, so scan-time supervision in software must allow for the slowest master.
         CFS_WAIT_IN: begin
            if (!run_q) begin
               state_d = CFS_IDLE;
            end else if (!wait_in || all_in) begin
               state_d = CFS_READ_IN;
            end
         end
         default: state_d = CFS_IDLE;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CFS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end
   // ------------------------------------------------------------
   // Input capture: set wins over the clear taken at input read.
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         got_q <= '0;
         in_cap_q <= '0;
      end else begin
         for (int i = 0; i < NM; i++) begin
            if (link.in_sync[i] && ena_q[i]) begin
               got_q[i] <= 1'b1;
               in_cap_q[i*DW +: DW] <= link.in_data[i*DW +: DW];
            end else if (state_q == CFS_READ_IN || !run_q) begin
               got_q[i] <= 1'b0;
            end
         end
      end
   end
   // The image is latched once per cycle so the program sees one data set.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_img_q <= CFS_CPU_DATA_RESET;
      end else if (state_q == CFS_READ_IN) begin
         in_img_q <= in_cap_q[DW-1:0];
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_sync_q <= 1'b0;
         out_data_q <= CFS_CPU_DATA_RESET;
         cycles_q <= 16'h0000;
      end else begin
         out_sync_q <= send_out;
         if (send_out) begin
            out_data_q <= out_reg_q;
         end
         if (state_q == CFS_READ_IN) begin
            cycles_q <= cycles_q + 16'h0001;
         end
      end
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= CFS_MODE_RESET;
         run_q <= 1'b0;
         ena_q <= '1;
         mlen_q <= CFS_MCYC_LEN_RESET;
         out_reg_q <= CFS_CPU_DATA_RESET;
      end else begin
         if (wr_ctrl && mode_ok) begin
            mode_q <= mode_wr;
         end
         if (wr_ctrl) begin
            run_q <= avs_writedata[CFS_CTRL_RUN_BIT];
         end
         if (wr_out) begin
            out_reg_q <= avs_writedata[DW-1:0];
         end
         if (wr_mcfg) begin
            ena_q <= avs_writedata[CFS_MCFG_ENA_LSB +: NM];
            mlen_q <= avs_writedata[CFS_MCFG_LEN_LSB +: 16];
         end
      end
   end
   // Master cycle length is exported through the config word only; masters use their own.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      case (avs_address)
         CFS_REG_CTRL: rd_mux = {26'h0000000, 1'b0, run_q, 1'b0, mode_q};
         CFS_REG_STATUS: rd_mux = {16'h0000, 8'h00, 4'h0, ~wait_in | all_in, dp_on, 2'(state_q)};
         CFS_REG_OUTDATA: rd_mux = 32'(out_reg_q);
         CFS_REG_INDATA: rd_mux = 32'(in_img_q);
         CFS_REG_CYCLES: rd_mux = {16'h0000, cycles_q};
         CFS_REG_MCFG: rd_mux = {mlen_q, 16'(ena_q)};
         CFS_REG_MSTAT: rd_mux = 32'(got_q);
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= acc;
         if (acc) begin
            rdata_q <= rd_mux;
         end
      end
   end
endmodule : cfsync_cpu
`default_nettype wire

// ---- cfsync_master.sv ----
// Fieldbus master end: NM master units, each with its own cycle timer.
// Assumes the CPU end drives mode, run and output pulses on the same mclk.
`timescale 1ns/1ns
`default_nettype none
module cfsync_master
   import cfsync_pkg::*;
#(
   parameter int NM = cfsync_pkg::CFS_NUM_MASTERS,
   parameter int DW = cfsync_pkg::CFS_DATA_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Per-master cycle lengths and input data from the slaves
   input wire logic [NM*16-1:0] cyc_len,
   input wire logic [NM*DW-1:0] slave_in,
   // Output data as delivered to the slaves
   output logic [NM*DW-1:0] slave_out,
   output logic [NM-1:0] cyc_busy,
   // Link to the CPU
   cfsync_if.master link
);
   import cfsync_pkg::*;
   wire logic dp_on = (link.mode != CFS_MODE_OFF) && (link.mode != CFS_MODE_PTP);
   wire logic gate_out = (link.mode == CFS_MODE_OUT) || (link.mode == CFS_MODE_MUTUAL);
   logic [NM-1:0] busy_q, pulse_q;
   logic [NM*16-1:0] cnt_q;
   logic [NM*DW-1:0] in_q, out_q;
   assign cyc_busy = busy_q;
   assign slave_out = out_q;
   assign link.in_sync = pulse_q;
   assign link.in_data = in_q;
   // ------------------------------------------------------------
   // One timer per master unit
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= '0;
         pulse_q <= '0;
         cnt_q <= '0;
         in_q <= '0;
         out_q <= '0;
      end else begin
         for (int i = 0; i < NM; i++) begin
            pulse_q[i] <= 1'b0;
            if (link.out_sync) begin
               out_q[i*DW +: DW] <= link.out_data;
            end
            if (!dp_on || !link.master_ena[i]) begin
               busy_q[i] <= 1'b0;
            end else if (!busy_q[i]) begin
               // Free run starts at once; gated modes wait for CPU output after start-up.
               if (!gate_out || (link.run && link.out_sync)) begin
                  busy_q[i] <= 1'b1;
                  cnt_q[i*16 +: 16] <= cyc_len[i*16 +: 16];
               end
            end else if (cnt_q[i*16 +: 16] <= 16'h0001) begin
               busy_q[i] <= 1'b0;
               pulse_q[i] <= 1'b1;
               in_q[i*DW +: DW] <= slave_in[i*DW +: DW];
            end else begin
               cnt_q[i*16 +: 16] <= cnt_q[i*16 +: 16] - 16'h0001;
            end
         end
      end
   end
endmodule : cfsync_master
`default_nettype wire

// ---- cfsync_props.sv ----
// Checker on the link signals between the CPU end and the master units.
// Assumes the bench wires it beside the interface instance, on mclk.
`timescale 1ns/1ns
`default_nettype none
module cfsync_props
   import cfsync_pkg::*;
#(parameter int NM = cfsync_pkg::CFS_NUM_MASTERS, parameter int DW = cfsync_pkg::CFS_DATA_W) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link signals
   input wire logic [2:0] mode,
   input wire logic run,
   input wire logic out_sync,
   input wire logic [DW-1:0] out_data,
   input wire logic [NM-1:0] in_sync,
   input wire logic [NM*DW-1:0] in_data,
   input wire logic [NM-1:0] master_ena
);
   import cfsync_pkg::*;
   // ----------------
   // Helpers
   // ----------------
   // Wait checks start only once no master cycle begun under the previous mode can still be running.
   logic [5:0] age_q;
   logic [2:0] mode_q;
   logic [NM-1:0] seen_q;
   wire old = &age_q;
   wire gate = mode == CFS_MODE_OUT || mode == CFS_MODE_MUTUAL;
   wire idle = mode == CFS_MODE_OFF || mode == CFS_MODE_PTP;
   wire [5:0] age_d = (mode != mode_q) ? 6'h00 : age_q + 6'(!old);
   wire [NM-1:0] seen_d = {NM{out_sync}} | (seen_q & ~in_sync);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= 6'h00;
         mode_q <= CFS_MODE_RESET;
         seen_q <= '0;
      end else begin
         age_q <= age_d;
         mode_q <= mode;
         seen_q <= seen_d;
      end
   end
   // ----------------
   // Assertions
   // ----------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence one_shot_s;
      out_sync ##1 !out_sync;
   endsequence
   rst_default_a:
      assert property (!$past(rst_n) |-> mode == CFS_MODE_RESET && !run && &master_ena)
      else $error("link not in reset state");
   mode_legal_a:
      assert property (mode <= CFS_MODE_MUTUAL) else $error("illegal mode");
   sync_gated_a:
      assert property (out_sync |-> run && !idle) else $error("output pulse while inactive");
   sync_pulse_a:
      assert property (out_sync |-> one_shot_s) else $error("output pulse too long");
   out_hold_a:
      assert property ($changed(out_data) |-> out_sync) else $error("output data moved alone");
   in_hold_a:
      assert property ($changed(in_data[DW-1:0]) |-> in_sync[0]) else $error("input data moved alone");
   master_wait_a:
      assert property (gate && run && old |-> (in_sync & master_ena & ~seen_q) == '0)
      else $error("master cycled without output pulse");
   silent_idle_a:
      assert property (idle && old |-> in_sync == '0) else $error("master active while off");
endmodule // cfsync_props
`default_nettype wire

// ---- cpu_fieldbus_cycle_sync_bench.sv ----
// Bench for the cycle synchronizer: both ends joined by the link interface.
// Assumes package, interface, both ends and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module cpu_fieldbus_cycle_sync_bench;
   import cfsync_pkg::*;
   // ----------------
   // Design and checker
   // ----------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic [31:0] cyc_len = {16'h0028, 16'h0003};
   logic [31:0] slave_in = {16'h5678, 16'h1234};
   logic [31:0] slave_out;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0, n_in0 = 0, n_in1 = 0, n_out = 0, os_t = 0, gap = 0;
   always #10 mclk = ~mclk;
   cfsync_if cfsync_if_i ();
   cfsync_cpu cfsync_cpu_i (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .link(cfsync_if_i.cpu));
   cfsync_master cfsync_master_i (.mclk(mclk), .rst_n(rst_n), .cyc_len(cyc_len), .slave_in(slave_in),
      .slave_out(slave_out), .cyc_busy(), .link(cfsync_if_i.master));
   cfsync_props cfsync_props_i (.mclk(mclk), .rst_n(rst_n), .mode(cfsync_if_i.mode), .run(cfsync_if_i.run),
      .out_sync(cfsync_if_i.out_sync), .out_data(cfsync_if_i.out_data), .in_sync(cfsync_if_i.in_sync),
      .in_data(cfsync_if_i.in_data), .master_ena(cfsync_if_i.master_ena));
   // Pulse counts and the gap from an output pulse to the slow master's input pulse.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      n_in0 <= n_in0 + int'(cfsync_if_i.in_sync[0]);
      n_in1 <= n_in1 + int'(cfsync_if_i.in_sync[1]);
      n_out <= n_out + int'(cfsync_if_i.out_sync);
      if (cfsync_if_i.out_sync) os_t <= cyc;
      if (cfsync_if_i.in_sync[1]) gap <= cyc - os_t;
   end
   // ----------------
   // Tasks
   // ----------------
   task automatic test_done();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge mclk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         // Waitrequest and read data are sampled at the rising edge, before that edge's updates land.
         @(posedge mclk);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      if (k >= 20) begin
         n_errors++;
         test_done();
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] m, input logic r, input logic d);
      return {26'h0, d, r, 1'b0, m};
   endfunction
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q & m, e);
   endtask
   task automatic wait_exec();
      logic [31:0] s;
      int k;
      k = 0;
      do begin
         bus(1'b0, CFS_REG_STATUS, 32'h0, s);
         k++;
      end while (s[1:0] !== 2'h2 && k < 60);
      if (k >= 60) begin
         n_errors++;
         test_done();
      end
   endtask
   // One program pass: mark done in EXEC, return cycles until EXEC again.
   task automatic pass(input logic [2:0] m, output int t);
      logic [31:0] c;
      logic [31:0] j;
      wait_exec();
      bus(1'b0, CFS_REG_CYCLES, 32'h0, c);
      t = cyc;
      bus(1'b1, CFS_REG_CTRL, ctl(m, 1'b1, 1'b1), j);
      wait_exec();
      t = cyc - t;
      rchk(CFS_REG_CYCLES, 32'hFFFFFFFF, c + 32'h1);
   endtask
   // ----------------
   // Sequence
   // ----------------
   initial begin
      logic [31:0] j;
      int t, a, b;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rchk(CFS_REG_CTRL, 32'h1F, 32'h02);
      rchk(CFS_REG_MCFG, 32'h3, 32'h3);
      rchk(4'hF, 32'hFFFFFFFF, 32'h0);
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, CFS_REG_CTRL, ctl(3'(m), 1'b1, 1'b0), j);
         repeat (50) @(posedge mclk);
         a = n_in0 + n_in1;
         b = n_out;
         bus(1'b1, CFS_REG_CTRL, ctl(3'(m), 1'b1, 1'b1), j);
         repeat (50) @(posedge mclk);
         check(32'(n_in0 + n_in1 - a + n_out - b), 32'h0);
      end
      bus(1'b1, CFS_REG_CTRL, ctl(3'h7, 1'b1, 1'b0), j);
      rchk(CFS_REG_CTRL, 32'h1F, 32'h11);
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_ASYNC, 1'b1, 1'b0), j);
      a = n_in0;
      b = n_in1;
      repeat (80) @(posedge mclk);
      check(32'(n_in0 - a > 12 && n_in1 - b < 4), 32'h1);
      pass(CFS_MODE_ASYNC, t);
      check(32'(t < 24), 32'h1);
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_IN, 1'b1, 1'b0), j);
      for (int e = 3; e > 0; e -= 2) begin
         bus(1'b1, CFS_REG_MCFG, 32'(e), j);
         // Early passes may find pulses already latched; by the fourth the slowest enabled master paces the CPU.
         for (int i = 0; i < 4; i++) begin
            pass(CFS_MODE_IN, t);
         end
         check(32'(t >= 24), 32'(e == 3));
      end
      bus(1'b1, CFS_REG_MCFG, 32'h3, j);
      // Masters are parked in gated mode, so on entering RUN the CPU must wait for fresh pulses.
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_OUT, 1'b0, 1'b0), j);
      repeat (50) @(posedge mclk);
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_IN, 1'b1, 1'b0), j);
      rchk(CFS_REG_STATUS, 32'hF, 32'h7);
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_MUTUAL, 1'b1, 1'b0), j);
      repeat (80) @(posedge mclk);
      // The first passes flush input pulses left over from the previous mode.
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            slave_in <= {16'h5678, 16'hBEEF};
            bus(1'b1, CFS_REG_OUTDATA, 32'h0000A5C3, j);
         end
         pass(CFS_MODE_MUTUAL, t);
      end
      check(32'(gap), 32'd41);
      check(slave_out, {2{16'hA5C3}});
      rchk(CFS_REG_INDATA, 32'hFFFF, 32'hBEEF);
      bus(1'b1, CFS_REG_CTRL, ctl(CFS_MODE_OUT, 1'b1, 1'b0), j);
      repeat (80) @(posedge mclk);
      bus(1'b1, CFS_REG_OUTDATA, 32'h00005AA5, j);
      a = n_in1;
      pass(CFS_MODE_OUT, t);
      check(32'(t < 24), 32'h1);
      repeat (100) @(posedge mclk);
      check(32'(n_in1 - a), 32'h1);
      check(slave_out, {2{16'h5AA5}});
      test_done();
   end
endmodule // cpu_fieldbus_cycle_sync_bench
`default_nettype wire
